//--- rtl/sleep_ctrl_regs.svh
// Register indices, field positions, reset values and timing of the power manager
`ifndef SLEEP_CTRL_REGS_SVH
`define SLEEP_CTRL_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_FAILURE_BACKUP_CONTROL 8'h00
`define IDX_SLEEP_CONFIG 8'h01
`define IDX_CORE_CLOCK_DIVIDE 8'h08
`define IDX_PERIPH_BUS_A_DIVIDE 8'h09
`define IDX_PERIPH_BUS_B_DIVIDE 8'h0A
`define IDX_PERIPH_BUS_C_DIVIDE 8'h0B
`define IDX_SYSTEM_BUS_CLOCK_GATES 8'h14
`define IDX_PERIPH_BUS_A_CLOCK_GATES 8'h18
`define IDX_PERIPH_BUS_B_CLOCK_GATES 8'h1C
`define IDX_PERIPH_BUS_C_CLOCK_GATES 8'h20
`define IDX_IRQ_ENABLE_CLEAR 8'h34
`define IDX_IRQ_ENABLE_SET 8'h35
`define IDX_IRQ_STATUS_FLAGS 8'h36
`define IDX_RESET_ORIGIN 8'h38
`define APB_IDX_HI 9
`define APB_IDX_LO 2

// Field positions
`define CTRL_BACKUP_BIT 4
`define CTRL_DETECT_BIT 2
`define IRQ_READY_BIT 0
`define IRQ_LOSS_BIT 1
`define IRQ_W 2
`define IDLE_W 2
`define DIV_W 3
`define ORIGIN_W 8
`define ORIGIN_POWER_UP_BIT 0
`define ORIGIN_CORE_DROOP_BIT 1
`define ORIGIN_HIGH_DROOP_BIT 2
`define ORIGIN_PIN_BIT 4
`define ORIGIN_WATCHDOG_BIT 5
`define ORIGIN_SOFTWARE_BIT 6

// Idle level codes
`define IDLE_CPU 2'h0
`define IDLE_AHB 2'h1
`define IDLE_APB 2'h2

// Clock gate masks: reset values and writable bits
`define SYS_GATES_RST 32'h0000007F
`define SYS_GATES_WMASK 32'h0000001F
`define BUS_A_GATES_RST 32'h0000007F
`define BUS_A_GATES_WMASK 32'h0000007F
`define BUS_B_GATES_RST 32'h0000007F
`define BUS_B_GATES_WMASK 32'h0000000F
`define BUS_C_GATES_RST 32'h00010000
`define BUS_C_GATES_WMASK 32'h000FFFFF

// Timing
`define CLK_PERIOD_NS 100
`define SETTLE_TIME_NS 400

`endif

//--- rtl/sleep_ctrl_pkg.sv
// Shared types of the sleep mode power controller
package sleep_ctrl_pkg;
  typedef enum logic [1:0] {ST_ACTIVE, ST_IDLE, ST_STANDBY} power_state_e;
  typedef logic [2:0] div_t;
endpackage : sleep_ctrl_pkg

//--- rtl/settle_if.sv
// Handshake between the register block and the clock settle timer
`timescale 1ns/1ns
`default_nettype none
interface settle_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport timer (input start, output busy, output done);
endinterface : settle_if
`default_nettype wire

//--- rtl/clock_settle_timer.sv
// Delay from a prescaler write until the new division is in effect
`timescale 1ns/1ns
`default_nettype none
`include "sleep_ctrl_regs.svh"
module clock_settle_timer #(
  parameter int SETTLE_NS = `SETTLE_TIME_NS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  settle_if.timer st
);
  localparam int RAW_CYC = (SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (RAW_CYC < 1) ? 1 : RAW_CYC;
  localparam int CW = $clog2(SETTLE_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(SETTLE_CYC - 1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CW-1:0] cnt;
  } timer_s;

  timer_s s_ff;
  timer_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    // A rewrite during the wait restarts it so the last setting is the one
    if (st.start) begin
      nxt_s.busy = 1'b1;
      nxt_s.cnt = '0;
    end else if (s_ff.busy) begin
      if (s_ff.cnt == LAST) begin
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
      end else begin
        nxt_s.cnt = s_ff.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign st.busy = s_ff.busy;
  assign st.done = s_ff.done;
endmodule : clock_settle_timer
`default_nettype wire

//--- rtl/sleep_mode_power_controller.sv
// Sleep mode, clock gating and interrupt logic of the power manager
// Functional notes
// - Wait-for-interrupt with deep sleep clear enters idle at configured level
// - Idle code 0 stops CPU, 1 adds system bus, 2 adds peripheral bus
// - Idle keeps oscillators, generic clock, regulator and RAM running normally
// - Stopped domain halts its modules whatever their clock mask bit says
// - Sleep after handler return also enters idle or standby as configured
// - Unmasked, high enough interrupt wakes idle and restarts stopped clocks
// - Idle 1 wakes on bus or async interrupts; idle 2, standby async only
// - Interrupts from generic, external clock or event count as asynchronous
// - Wait-for-interrupt with deep sleep set enters standby
// - Standby stops bus, CPU, generic clocks; oscillators by their own bits
// - Standby puts regulator and RAM in low power; idle keeps them normal
// - Enabled asynchronous interrupt wakes the device from standby
// - In standby a peripheral may get its generic clock on demand
// - Clock ready bit 0 and clock loss bit 1 flags set on their events
// - Enable set and clear registers act on ones, ignore zeros
// - Interrupt asserted while any flag and its enable are both set
// - Controller runs in idle, frozen in standby until async wake; here bus writes and the ready flag still update in standby
// - Clock ready reads zero after a prescaler write until settings apply
// - Clock failure switches to backup oscillator, sets flag and select bit
// - Reset origin reports the latest reset source in six bits
`timescale 1ns/1ns
`default_nettype none
`include "sleep_ctrl_regs.svh"
module sleep_mode_power_controller #(
  parameter int NIRQ = 8,
  parameter int NOSC = 4,
  parameter int SETTLE_NS = `SETTLE_TIME_NS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wait_for_interrupt_instruction,
  input wire logic deep_sleep_select,
  input wire logic sleep_after_handler_return,
  input wire logic lowest_handler_return,
  input wire logic [NIRQ-1:0] sync_irq_wake,
  input wire logic [NIRQ-1:0] async_irq_wake,
  input wire logic generic_clock_request,
  input wire logic [NOSC-1:0] keep_running_in_deep_sleep,
  input wire logic [NOSC-1:0] request_gated_run,
  input wire logic [NOSC-1:0] osc_requested,
  input wire logic main_clock_failed,
  input wire logic [5:0] reset_source,
  output logic cpu_clk_en,
  output logic ahb_clk_en,
  output logic apb_clk_en,
  output logic generic_clock_run,
  output logic regulator_low_power,
  output logic ram_low_power,
  output logic [NOSC-1:0] osc_run,
  output logic [31:0] sys_gate_en,
  output logic [31:0] bus_a_gate_en,
  output logic [31:0] bus_b_gate_en,
  output logic [31:0] bus_c_gate_en,
  output sleep_ctrl_pkg::div_t core_prescale_sel,
  output sleep_ctrl_pkg::div_t bus_a_prescale_sel,
  output sleep_ctrl_pkg::div_t bus_b_prescale_sel,
  output sleep_ctrl_pkg::div_t bus_c_prescale_sel,
  output logic backup_clock_selected,
  output logic failure_detector_on,
  output logic irq
);
  //**************************************************************
  // State
  //**************************************************************
  typedef struct packed {
    sleep_ctrl_pkg::power_state_e mode;
    logic [`IDLE_W-1:0] idle_lvl;
    logic [`IDLE_W-1:0] idle_cfg;
    logic backup;
    logic detect_on;
    sleep_ctrl_pkg::div_t core_div;
    sleep_ctrl_pkg::div_t a_div;
    sleep_ctrl_pkg::div_t b_div;
    sleep_ctrl_pkg::div_t c_div;
    logic [31:0] sys_mask;
    logic [31:0] a_mask;
    logic [31:0] b_mask;
    logic [31:0] c_mask;
    logic [`IRQ_W-1:0] irq_en;
    logic [`IRQ_W-1:0] flags;
    logic [`ORIGIN_W-1:0] origin;
    logic origin_taken;
    logic pready;
    logic [31:0] prdata;
    logic irq;
    logic cpu_en;
    logic ahb_en;
    logic apb_en;
    logic generic_clock_unit_run;
    logic low_power;
    logic [NOSC-1:0] osc_run;
    logic [31:0] sys_gate;
    logic [31:0] a_gate;
    logic [31:0] b_gate;
    logic [31:0] c_gate;
  } ctrl_s;

  ctrl_s s_ff;
  ctrl_s nxt_s;
  settle_if settle ();
  logic [NOSC-1:0] osc_idle_run;
  logic [NOSC-1:0] osc_deep_run;

  clock_settle_timer #(.SETTLE_NS(SETTLE_NS)) u_settle (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .st(settle)
  );

  //**************************************************************
  // Oscillator run requests
  //**************************************************************
  for (genvar i = 0; i < NOSC; i++) begin : g_osc
    assign osc_idle_run[i] = !request_gated_run[i] || osc_requested[i];
    assign osc_deep_run[i] = keep_running_in_deep_sleep[i] &&
                             osc_idle_run[i];
  end

  //**************************************************************
  // Next state
  //**************************************************************
  logic access;
  logic wr;
  logic [7:0] idx;
  logic div_wr;
  logic sleep_req;
  logic wake;
  logic loss_evt;
  logic [31:0] rd;

  assign idx = paddr[`APB_IDX_HI:`APB_IDX_LO];
  assign access = psel && penable && s_ff.pready;
  assign wr = access && pwrite;
  assign div_wr = wr && (idx == `IDX_CORE_CLOCK_DIVIDE ||
                         idx == `IDX_PERIPH_BUS_A_DIVIDE ||
                         idx == `IDX_PERIPH_BUS_B_DIVIDE ||
                         idx == `IDX_PERIPH_BUS_C_DIVIDE);
  assign settle.start = div_wr && ce;
  assign sleep_req = wait_for_interrupt_instruction ||
                     (sleep_after_handler_return &&
                      lowest_handler_return);
  assign loss_evt = main_clock_failed && s_ff.detect_on &&
                    s_ff.mode == sleep_ctrl_pkg::ST_ACTIVE;

  always_comb begin
    rd = '0;
    unique case (idx)
      `IDX_FAILURE_BACKUP_CONTROL: begin
        rd[`CTRL_BACKUP_BIT] = s_ff.backup;
        rd[`CTRL_DETECT_BIT] = s_ff.detect_on;
      end
      `IDX_SLEEP_CONFIG: rd[`IDLE_W-1:0] = s_ff.idle_cfg;
      `IDX_CORE_CLOCK_DIVIDE: rd[`DIV_W-1:0] = s_ff.core_div;
      `IDX_PERIPH_BUS_A_DIVIDE: rd[`DIV_W-1:0] = s_ff.a_div;
      `IDX_PERIPH_BUS_B_DIVIDE: rd[`DIV_W-1:0] = s_ff.b_div;
      `IDX_PERIPH_BUS_C_DIVIDE: rd[`DIV_W-1:0] = s_ff.c_div;
      `IDX_SYSTEM_BUS_CLOCK_GATES: rd = s_ff.sys_mask;
      `IDX_PERIPH_BUS_A_CLOCK_GATES: rd = s_ff.a_mask;
      `IDX_PERIPH_BUS_B_CLOCK_GATES: rd = s_ff.b_mask;
      `IDX_PERIPH_BUS_C_CLOCK_GATES: rd = s_ff.c_mask;
      `IDX_IRQ_ENABLE_CLEAR: rd[`IRQ_W-1:0] = s_ff.irq_en;
      `IDX_IRQ_ENABLE_SET: rd[`IRQ_W-1:0] = s_ff.irq_en;
      `IDX_IRQ_STATUS_FLAGS: rd[`IRQ_W-1:0] = s_ff.flags;
      `IDX_RESET_ORIGIN: rd[`ORIGIN_W-1:0] = s_ff.origin;
      default: rd = '0;
    endcase
  end

  always_comb begin
    nxt_s = s_ff;
    wake = 1'b0;
    // One wait state: pready rises one cycle into the access phase
    nxt_s.pready = psel && penable && !s_ff.pready;
    if (psel && penable && !s_ff.pready) begin
      nxt_s.prdata = pwrite ? '0 : rd;
    end

    if (wr) begin
      unique case (idx)
        `IDX_FAILURE_BACKUP_CONTROL: begin
          nxt_s.backup = pwdata[`CTRL_BACKUP_BIT];
          nxt_s.detect_on = pwdata[`CTRL_DETECT_BIT];
        end
        `IDX_SLEEP_CONFIG: nxt_s.idle_cfg = pwdata[`IDLE_W-1:0];
        `IDX_CORE_CLOCK_DIVIDE: nxt_s.core_div = pwdata[`DIV_W-1:0];
        `IDX_PERIPH_BUS_A_DIVIDE: nxt_s.a_div = pwdata[`DIV_W-1:0];
        `IDX_PERIPH_BUS_B_DIVIDE: nxt_s.b_div = pwdata[`DIV_W-1:0];
        `IDX_PERIPH_BUS_C_DIVIDE: nxt_s.c_div = pwdata[`DIV_W-1:0];
        `IDX_SYSTEM_BUS_CLOCK_GATES:
          nxt_s.sys_mask = pwdata & `SYS_GATES_WMASK;
        `IDX_PERIPH_BUS_A_CLOCK_GATES:
          nxt_s.a_mask = pwdata & `BUS_A_GATES_WMASK;
        `IDX_PERIPH_BUS_B_CLOCK_GATES:
          nxt_s.b_mask = pwdata & `BUS_B_GATES_WMASK;
        `IDX_PERIPH_BUS_C_CLOCK_GATES:
          nxt_s.c_mask = pwdata & `BUS_C_GATES_WMASK;
        `IDX_IRQ_ENABLE_CLEAR:
          nxt_s.irq_en = s_ff.irq_en & ~pwdata[`IRQ_W-1:0];
        `IDX_IRQ_ENABLE_SET:
          nxt_s.irq_en = s_ff.irq_en | pwdata[`IRQ_W-1:0];
        `IDX_IRQ_STATUS_FLAGS:
          nxt_s.flags = s_ff.flags & ~pwdata[`IRQ_W-1:0];
        default: ;
      endcase
    end

    // Old settings no longer apply once a prescaler is rewritten
    if (div_wr) begin
      nxt_s.flags[`IRQ_READY_BIT] = 1'b0;
    end
    // Hardware sets win over a software clear in the same cycle
    if (settle.done) begin
      nxt_s.flags[`IRQ_READY_BIT] = 1'b1;
    end
    if (loss_evt) begin
      nxt_s.flags[`IRQ_LOSS_BIT] = 1'b1;
      nxt_s.backup = 1'b1;
    end

    // Latch reset origin once, on the first enabled cycle after release
    if (!s_ff.origin_taken) begin
      nxt_s.origin_taken = 1'b1;
      nxt_s.origin = '0;
      nxt_s.origin[`ORIGIN_POWER_UP_BIT] = reset_source[0];
      nxt_s.origin[`ORIGIN_CORE_DROOP_BIT] = reset_source[1];
      nxt_s.origin[`ORIGIN_HIGH_DROOP_BIT] = reset_source[2];
      nxt_s.origin[`ORIGIN_PIN_BIT] = reset_source[3];
      nxt_s.origin[`ORIGIN_WATCHDOG_BIT] = reset_source[4];
      nxt_s.origin[`ORIGIN_SOFTWARE_BIT] = reset_source[5];
    end

    //************************************************************
    // Sleep sequencing
    //************************************************************
    unique case (s_ff.mode)
      sleep_ctrl_pkg::ST_ACTIVE: begin
        if (sleep_req) begin
          if (deep_sleep_select) begin
            nxt_s.mode = sleep_ctrl_pkg::ST_STANDBY;
          end else begin
            nxt_s.mode = sleep_ctrl_pkg::ST_IDLE;
            nxt_s.idle_lvl = s_ff.idle_cfg;
          end
        end
      end
      sleep_ctrl_pkg::ST_IDLE: begin
        // Levels 0 and 1 take bus clocked wakes; 2 and up only async
        if (s_ff.idle_lvl == `IDLE_CPU || s_ff.idle_lvl == `IDLE_AHB) begin
          wake = |(sync_irq_wake | async_irq_wake);
        end else begin
          wake = |async_irq_wake;
        end
        if (wake) begin
          nxt_s.mode = sleep_ctrl_pkg::ST_ACTIVE;
        end
      end
      sleep_ctrl_pkg::ST_STANDBY: begin
        // Registers keep updating from the bus and settle timer; only the async wake is watched
        wake = |async_irq_wake;
        if (wake) begin
          nxt_s.mode = sleep_ctrl_pkg::ST_ACTIVE;
        end
      end
    endcase

    //************************************************************
    // Clock domain and power outputs from the coming mode
    //************************************************************
    unique case (nxt_s.mode)
      sleep_ctrl_pkg::ST_ACTIVE: begin
        nxt_s.cpu_en = 1'b1;
        nxt_s.ahb_en = 1'b1;
        nxt_s.apb_en = 1'b1;
        nxt_s.generic_clock_unit_run = 1'b1;
        nxt_s.low_power = 1'b0;
        nxt_s.osc_run = osc_idle_run;
      end
      sleep_ctrl_pkg::ST_IDLE: begin
        nxt_s.cpu_en = 1'b0;
        nxt_s.ahb_en = (nxt_s.idle_lvl == `IDLE_CPU);
        // Reserved code 3 is handled as the deepest idle level
        nxt_s.apb_en = (nxt_s.idle_lvl == `IDLE_CPU ||
                        nxt_s.idle_lvl == `IDLE_AHB);
        nxt_s.generic_clock_unit_run = 1'b1;
        nxt_s.low_power = 1'b0;
        nxt_s.osc_run = osc_idle_run;
      end
      sleep_ctrl_pkg::ST_STANDBY: begin
        nxt_s.cpu_en = 1'b0;
        nxt_s.ahb_en = 1'b0;
        nxt_s.apb_en = 1'b0;
        nxt_s.generic_clock_unit_run = generic_clock_request;
        nxt_s.low_power = 1'b1;
        nxt_s.osc_run = osc_deep_run;
      end
    endcase

    // Stopped domain overrides every mask bit
    nxt_s.sys_gate = nxt_s.ahb_en ? nxt_s.sys_mask : '0;
    nxt_s.a_gate = nxt_s.apb_en ? nxt_s.a_mask : '0;
    nxt_s.b_gate = nxt_s.apb_en ? nxt_s.b_mask : '0;
    nxt_s.c_gate = nxt_s.apb_en ? nxt_s.c_mask : '0;

    nxt_s.irq = |(nxt_s.flags & nxt_s.irq_en);
  end

  //**************************************************************
  // Registers
  //**************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
      s_ff.mode <= sleep_ctrl_pkg::ST_ACTIVE;
      s_ff.sys_mask <= `SYS_GATES_RST & `SYS_GATES_WMASK;
      s_ff.a_mask <= `BUS_A_GATES_RST & `BUS_A_GATES_WMASK;
      s_ff.b_mask <= `BUS_B_GATES_RST & `BUS_B_GATES_WMASK;
      s_ff.c_mask <= `BUS_C_GATES_RST & `BUS_C_GATES_WMASK;
      s_ff.flags <= `IRQ_W'(1) << `IRQ_READY_BIT;
      s_ff.cpu_en <= 1'b1;
      s_ff.ahb_en <= 1'b1;
      s_ff.apb_en <= 1'b1;
      s_ff.generic_clock_unit_run <= 1'b1;
      s_ff.osc_run <= '1;
      s_ff.sys_gate <= `SYS_GATES_RST & `SYS_GATES_WMASK;
      s_ff.a_gate <= `BUS_A_GATES_RST & `BUS_A_GATES_WMASK;
      s_ff.b_gate <= `BUS_B_GATES_RST & `BUS_B_GATES_WMASK;
      s_ff.c_gate <= `BUS_C_GATES_RST & `BUS_C_GATES_WMASK;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = 1'b0;
  assign cpu_clk_en = s_ff.cpu_en;
  assign ahb_clk_en = s_ff.ahb_en;
  assign apb_clk_en = s_ff.apb_en;
  assign generic_clock_run = s_ff.generic_clock_unit_run;
  assign regulator_low_power = s_ff.low_power;
  assign ram_low_power = s_ff.low_power;
  assign osc_run = s_ff.osc_run;
  assign sys_gate_en = s_ff.sys_gate;
  assign bus_a_gate_en = s_ff.a_gate;
  assign bus_b_gate_en = s_ff.b_gate;
  assign bus_c_gate_en = s_ff.c_gate;
  assign core_prescale_sel = s_ff.core_div;
  assign bus_a_prescale_sel = s_ff.a_div;
  assign bus_b_prescale_sel = s_ff.b_div;
  assign bus_c_prescale_sel = s_ff.c_div;
  assign backup_clock_selected = s_ff.backup;
  assign failure_detector_on = s_ff.detect_on;
  assign irq = s_ff.irq;
endmodule : sleep_mode_power_controller
`default_nettype wire

//--- bench/sleep_ctrl_monitor.sv
// Port checker of the sleep mode power controller
`timescale 1ns/1ns
`default_nettype none
module sleep_ctrl_monitor #(
  parameter int NIRQ = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic wait_for_interrupt_instruction,
  input wire logic deep_sleep_select,
  input wire logic sleep_after_handler_return,
  input wire logic lowest_handler_return,
  input wire logic [NIRQ-1:0] sync_irq_wake,
  input wire logic [NIRQ-1:0] async_irq_wake,
  input wire logic main_clock_failed,
  input wire logic cpu_clk_en,
  input wire logic ahb_clk_en,
  input wire logic apb_clk_en,
  input wire logic regulator_low_power,
  input wire logic ram_low_power,
  input wire logic [31:0] sys_gate_en,
  input wire logic [31:0] bus_a_gate_en,
  input wire logic backup_clock_selected,
  input wire logic failure_detector_on
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Sleep request only counts while the core is running
  sequence s_sleep_req(d);
    cpu_clk_en && deep_sleep_select == d &&
      (wait_for_interrupt_instruction ||
      (sleep_after_handler_return && lowest_handler_return));
  endsequence
  a_idle_entry: assert property (
    s_sleep_req(1'b0) |=> !cpu_clk_en && !regulator_low_power)
    else $error("idle entry wrong");
  a_standby_entry: assert property (
    s_sleep_req(1'b1) |=> !cpu_clk_en && regulator_low_power)
    else $error("standby entry wrong");
  a_low_power_pair: assert property (
    regulator_low_power || ram_low_power |->
      regulator_low_power && ram_low_power && !apb_clk_en)
    else $error("low power outside standby");
  a_domain_nesting: assert property (
    (!apb_clk_en |-> !ahb_clk_en) and (!ahb_clk_en |-> !cpu_clk_en))
    else $error("domains stopped out of order");
  // Two cycles allowed so a gate may lag its domain by one
  a_gates_halt: assert property (
    !apb_clk_en [*2] |-> sys_gate_en == 32'h0 && bus_a_gate_en == 32'h0)
    else $error("gate open in stopped domain");
  a_async_wake: assert property (
    !cpu_clk_en && |async_irq_wake |=> cpu_clk_en)
    else $error("async wake missed");
  a_sync_wake: assert property (
    !cpu_clk_en && apb_clk_en && |sync_irq_wake |=> cpu_clk_en)
    else $error("bus wake missed");
  a_sync_ignored: assert property (
    !apb_clk_en && !(|async_irq_wake) |=> !cpu_clk_en)
    else $error("woke without async interrupt");
  a_loss_backup: assert property (
    main_clock_failed && failure_detector_on && cpu_clk_en |=>
      backup_clock_selected)
    else $error("backup clock not selected");
  a_ready_pulse: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer not one pulse");
endmodule : sleep_ctrl_monitor
bind sleep_mode_power_controller sleep_ctrl_monitor #(.NIRQ(NIRQ)) i_mon (
  .clk, .rst_b, .psel, .penable, .pready, .wait_for_interrupt_instruction,
  .deep_sleep_select, .sleep_after_handler_return, .lowest_handler_return,
  .sync_irq_wake, .async_irq_wake, .main_clock_failed, .cpu_clk_en,
  .ahb_clk_en, .apb_clk_en, .regulator_low_power, .ram_low_power,
  .sys_gate_en, .bus_a_gate_en, .backup_clock_selected, .failure_detector_on);
`default_nettype wire

//--- bench/core_model.sv
// Processor core model: register bus master and sleep requests
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic wait_for_interrupt_instruction,
  output logic deep_sleep_select,
  output logic sleep_after_handler_return,
  output logic lowest_handler_return
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {wait_for_interrupt_instruction, deep_sleep_select} = '0;
    {sleep_after_handler_return, lowest_handler_return} = '0;
  end
  // Request held until pready is high at a rising edge
  task xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Hand back off the edge so callers look at settled outputs
    @(negedge clk);
  endtask : xfer
  task enter_sleep(input logic deep, input logic on_return);
    @(posedge clk);
    deep_sleep_select <= deep;
    wait_for_interrupt_instruction <= !on_return;
    sleep_after_handler_return <= on_return;
    lowest_handler_return <= on_return;
    @(posedge clk);
    wait_for_interrupt_instruction <= 1'b0;
    lowest_handler_return <= 1'b0;
  endtask : enter_sleep
endmodule : core_model
`default_nettype wire

//--- bench/sleep_mode_power_controller_tb_top.sv
// Self-checking bench of the sleep mode power controller
`timescale 1ns/1ns
`default_nettype none
`include "sleep_ctrl_regs.svh"
module sleep_mode_power_controller_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel, penable, pwrite, pready, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, sys_gate_en, bus_a_gate_en;
  logic wait_for_interrupt_instruction, deep_sleep_select;
  logic sleep_after_handler_return, lowest_handler_return;
  logic [7:0] sync_irq_wake = 8'h00;
  logic [7:0] async_irq_wake = 8'h00;
  logic ce = 1'b1;
  logic generic_clock_request = 1'b1;
  logic main_clock_failed = 1'b0;
  logic [3:0] keep_running_in_deep_sleep = 4'h5;
  logic [3:0] request_gated_run = 4'h3;
  logic [3:0] osc_requested = 4'h1;
  logic [3:0] osc_run;
  logic [5:0] reset_source = 6'h29;
  logic cpu_clk_en, ahb_clk_en, apb_clk_en, generic_clock_run;
  logic regulator_low_power, ram_low_power, backup_clock_selected;
  logic failure_detector_on;
  sleep_ctrl_pkg::div_t core_prescale_sel;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] idx_t [15] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h0A, 8'h0B,
    8'h14, 8'h18, 8'h1C, 8'h20, 8'h34, 8'h35, 8'h36, 8'h38, 8'h02};
  logic [31:0] rst_t [15] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    `SYS_GATES_RST & `SYS_GATES_WMASK, `BUS_A_GATES_RST & `BUS_A_GATES_WMASK,
    `BUS_B_GATES_RST & `BUS_B_GATES_WMASK, `BUS_C_GATES_RST & `BUS_C_GATES_WMASK,
    32'h0, 32'h0, 32'h1, 32'h51, 32'h0};
  logic [31:0] one_t [15] = '{32'h14, 32'h3, 32'h7, 32'h7, 32'h7, 32'h7,
    `SYS_GATES_WMASK, `BUS_A_GATES_WMASK, `BUS_B_GATES_WMASK,
    `BUS_C_GATES_WMASK, 32'h0, 32'h0, 32'h0, 32'h51, 32'h0};
  logic [2:0] exp_dom [4] = '{3'b011, 3'b001, 3'b000, 3'b000};
  sleep_mode_power_controller i_dut (.clk, .rst_b, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(),
    .wait_for_interrupt_instruction, .deep_sleep_select,
    .sleep_after_handler_return, .lowest_handler_return, .sync_irq_wake,
    .async_irq_wake, .generic_clock_request, .keep_running_in_deep_sleep,
    .request_gated_run, .osc_requested, .main_clock_failed, .reset_source,
    .cpu_clk_en, .ahb_clk_en, .apb_clk_en, .generic_clock_run,
    .regulator_low_power, .ram_low_power, .osc_run, .sys_gate_en,
    .bus_a_gate_en, .bus_b_gate_en(), .bus_c_gate_en(), .core_prescale_sel,
    .bus_a_prescale_sel(), .bus_b_prescale_sel(), .bus_c_prescale_sel(),
    .backup_clock_selected, .failure_detector_on, .irq);
  core_model i_core (.clk, .pready, .prdata, .psel, .penable, .pwrite,
    .paddr, .pwdata, .wait_for_interrupt_instruction, .deep_sleep_select,
    .sleep_after_handler_return, .lowest_handler_return);
  always #50 clk = ~clk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rdchk(input logic [7:0] idx, input logic [31:0] exp);
    i_core.xfer(1'b0, idx, 32'h0, q);
    chk(q, exp);
  endtask : rdchk
  task wr(input logic [7:0] idx, input logic [31:0] d);
    i_core.xfer(1'b1, idx, d, q);
  endtask : wr
  task pulse_irq(input logic async_src);
    @(posedge clk);
    if (async_src) async_irq_wake <= 8'h80;
    else sync_irq_wake <= 8'h01;
    @(posedge clk);
    {sync_irq_wake, async_irq_wake} <= 16'h0;
    @(negedge clk);
  endtask : pulse_irq
  task results;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 15; i++) rdchk(idx_t[i], rst_t[i]);
    for (int i = 0; i < 15; i++) begin
      if (i < 10 || i > 12) begin
        wr(idx_t[i], 32'hFFFFFFFF);
        rdchk(idx_t[i], one_t[i]);
      end
    end
    for (int lv = 0; lv < 4; lv++) begin
      wr(8'h01, lv);
      i_core.enter_sleep(1'b0, lv == 1);
      @(negedge clk);
      chk({cpu_clk_en, ahb_clk_en, apb_clk_en}, exp_dom[lv]);
      chk({regulator_low_power, ram_low_power}, 2'b00);
      @(negedge clk);
      chk(sys_gate_en, lv == 0 ? `SYS_GATES_WMASK : 32'h0);
      chk(bus_a_gate_en, lv < 2 ? `BUS_A_GATES_WMASK : 32'h0);
      chk({generic_clock_run, osc_run}, 5'h1D);
      pulse_irq(1'b0);
      chk(cpu_clk_en, lv < 2);
      pulse_irq(1'b1);
      chk({cpu_clk_en, ahb_clk_en, apb_clk_en}, 3'b111);
    end
    i_core.enter_sleep(1'b1, 1'b0);
    @(negedge clk);
    chk({cpu_clk_en, ahb_clk_en, apb_clk_en}, 3'b000);
    chk({regulator_low_power, ram_low_power, generic_clock_run}, 3'b111);
    @(posedge clk) generic_clock_request <= 1'b0;
    repeat (2) @(negedge clk);
    chk({generic_clock_run, osc_run}, 5'h05);
    pulse_irq(1'b0);
    chk(cpu_clk_en, 1'b0);
    pulse_irq(1'b1);
    chk({cpu_clk_en, regulator_low_power}, 2'b10);
    wr(8'h35, 32'h1);
    wr(8'h08, 32'h5);
    rdchk(8'h36, 32'h0);
    chk({irq, core_prescale_sel}, 4'h5);
    repeat (6) @(negedge clk);
    chk(irq, 1'b1);
    rdchk(8'h36, 32'h1);
    wr(8'h35, 32'h0);
    wr(8'h34, 32'h0);
    chk(irq, 1'b1);
    wr(8'h34, 32'h1);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    rdchk(8'h35, 32'h0);
    wr(8'h35, 32'h3);
    repeat (2) @(negedge clk);
    chk(irq, 1'b1);
    wr(8'h36, 32'h1);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    wr(8'h00, 32'h4);
    @(posedge clk) main_clock_failed <= 1'b1;
    @(posedge clk) main_clock_failed <= 1'b0;
    @(negedge clk);
    chk({backup_clock_selected, failure_detector_on, irq}, 3'b111);
    rdchk(8'h36, 32'h2);
    rdchk(8'h00, 32'h14);
    // A low clock enable must hold the settle timer and the ready flag
    wr(8'h09, 32'h2);
    @(posedge clk) ce <= 1'b0;
    repeat (8) @(negedge clk);
    @(posedge clk) ce <= 1'b1;
    rdchk(8'h36, 32'h2);
    rdchk(8'h36, 32'h3);
    results();
  end
endmodule : sleep_mode_power_controller_tb_top
`default_nettype wire
